// ===== verilog/cpc_top.sv
// Charger pin control logic: indicator, alert, enables, limits, data lines
// Overview of operation
// - Indicator driven low while charging is in progress.
// - Indicator released high when charging completes or is disabled.
// - Any fault blinks the indicator at 1 Hz instead.
// - Indicator disable bit stops driving the indicator.
// - Status change or fault sends one 256 us low alert pulse.
// - Boost only when boost config bit is 1 and request pin high.
// - Charging only when allow bit is 1 and enable pin low.
// - Pin limit select high: use smaller of pin and code limits.
// - Pin limit select low: use only the code limit.
// - Resistor limit path does not go below 500 mA.
// - Data lines driven by their codes only with source or boost.
// - Port detection: contact, primary, secondary, adapter checks.
// - Charging suspended while thermistor is out of window.
`timescale 1ns/1ns
`default_nettype none
module cpc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Host pins
    input wire logic boost_request_pin,
    input wire logic charge_enable_n_pin,
    output logic stat_out,
    output logic stat_oe_n,
    output logic alert_out,
    output logic alert_oe_n,
    // Configuration bits
    input wire logic indicator_disable_bit,
    input wire logic boost_config_bit,
    input wire logic charger_allow_bit,
    input wire logic pin_limit_select_bit,
    input wire logic [5:0] input_limit_code,
    input wire logic [2:0] dplus_drive_code,
    input wire logic [2:0] dminus_drive_code,
    // Analog front end status
    input wire logic [5:0] input_limit_pin,
    input wire logic thermistor_in,
    input wire logic source_attached,
    input wire logic charge_done,
    input wire logic fault_present,
    // USB data lines
    input wire logic dplus_in,
    input wire logic dminus_in,
    output logic [2:0] dplus_out,
    output logic dplus_oe_n,
    output logic [2:0] dminus_out,
    output logic dminus_oe_n,
    // Control results
    output logic boost_active,
    output logic charge_active,
    output logic [5:0] input_limit_eff,
    output logic detect_busy,
    output cpc_pkg::cpc_port_t port_type
);
    // Synchronisers for pins, index 0..6
    localparam int unsigned NSYNC = 7;
    logic [NSYNC-1:0] raw, s1_q, s2_q;
    assign raw = {source_attached, dminus_in, dplus_in, thermistor_in,
                  charge_enable_n_pin, boost_request_pin, fault_present};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // Two stage synchroniser
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    logic fault_s, boost_req_s, ce_n_s, temp_ok_s, dp_s, dm_s, src_s;
    assign fault_s = s2_q[0];
    assign boost_req_s = s2_q[1];
    assign ce_n_s = s2_q[2];
    assign temp_ok_s = s2_q[3];
    assign dp_s = s2_q[4];
    assign dm_s = s2_q[5];
    assign src_s = s2_q[6];

    // Clamp a pin limit code to the resistor path minimum
    function automatic logic [5:0] pin_clamp(input logic [5:0] c);
        pin_clamp = (c < cpc_pkg::PIN_LIMIT_MIN_CODE)
            ? cpc_pkg::PIN_LIMIT_MIN_CODE : c;
    endfunction

    // Control group: enables and limit
    logic boost_q, boost_d, chg_q, chg_d;
    logic [5:0] lim_q, lim_d, pin_lim;
    always_comb begin
        boost_d = boost_config_bit && boost_req_s;
        chg_d = charger_allow_bit && !ce_n_s && temp_ok_s && !boost_d;
        pin_lim = pin_clamp(input_limit_pin);
        if (pin_limit_select_bit && pin_lim < input_limit_code)
            lim_d = pin_lim;
        else
            lim_d = input_limit_code;
    end

    // Control registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            boost_q <= 1'b0;
            chg_q <= 1'b0;
            lim_q <= 6'h00;
        end else begin
            boost_q <= boost_d;
            chg_q <= chg_d;
            lim_q <= lim_d;
        end
    end
    assign boost_active = boost_q;
    assign charge_active = chg_q;
    assign input_limit_eff = lim_q;

    // Indicator group: blink timer and pin level
    logic [27:0] blink_cnt_q, blink_cnt_d;
    logic blink_q, blink_d, stat_oen_q, stat_oen_d;
    logic charging;
    assign charging = chg_q && !charge_done;
    always_comb begin
        blink_cnt_d = blink_cnt_q + 28'h0000001;
        blink_d = blink_q;
        if (!fault_s) begin
            blink_cnt_d = 28'h0000000;
            blink_d = 1'b0;
        end else if (blink_cnt_q == 28'(cpc_pkg::BLINK_HALF_CYC - 1)) begin
            blink_cnt_d = 28'h0000000;
            blink_d = !blink_q;
        end
        if (indicator_disable_bit) begin
            stat_oen_d = 1'b1;
        end else if (fault_s) begin
            stat_oen_d = blink_q;
        end else if (charging) begin
            stat_oen_d = 1'b0;
        end else begin
            stat_oen_d = 1'b1;
        end
    end

    // Indicator registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            blink_cnt_q <= 28'h0000000;
            blink_q <= 1'b0;
            stat_oen_q <= cpc_pkg::STAT_RST;
        end else begin
            blink_cnt_q <= blink_cnt_d;
            blink_q <= blink_d;
            stat_oen_q <= stat_oen_d;
        end
    end
    assign stat_out = 1'b0;
    assign stat_oe_n = stat_oen_q;

    // Alert group: status change detection and pulse timer
    logic [4:0] stat_vec, prev_q, prev_d;
    logic [16:0] al_cnt_q, al_cnt_d;
    logic al_q, al_d, pend_q, pend_d, event_now;
    assign stat_vec = {fault_s, chg_q, boost_q, src_s, charge_done};
    assign event_now = (stat_vec != prev_q);
    always_comb begin
        prev_d = stat_vec;
        al_d = al_q;
        al_cnt_d = al_cnt_q;
        // Events during a pulse are held and reported afterwards
        pend_d = pend_q || (event_now && al_q);
        if (al_q) begin
            al_cnt_d = al_cnt_q + 17'h00001;
            if (al_cnt_q == 17'(cpc_pkg::ALERT_PULSE_CYC - 1)) begin
                al_d = 1'b0;
                al_cnt_d = 17'h00000;
            end
        end else if (event_now || pend_q) begin
            al_d = 1'b1;
            al_cnt_d = 17'h00000;
            pend_d = 1'b0;
        end
    end

    // Alert registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_q <= 5'h00;
            al_cnt_q <= 17'h00000;
            al_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            al_cnt_q <= al_cnt_d;
            al_q <= al_d;
            pend_q <= pend_d;
        end
    end
    assign alert_out = 1'b0;
    assign alert_oe_n = !al_q;

    // Data line group: detection start and drivers
    cpc_det_if dif ();
    logic src_prev_q, drv_q, drv_d;
    logic [2:0] dp_q, dp_d, dm_q, dm_d;
    assign dif.start = src_s && !src_prev_q;
    assign dif.dp_in = dp_s;
    assign dif.dm_in = dm_s;
    always_comb begin
        // drive only with source or boost, not while detecting
        // Start cycle counts as busy so no one-cycle drive slips through
        drv_d = (src_s || boost_q) && !dif.busy && !dif.start;
        dp_d = drv_d ? dplus_drive_code : 3'h0;
        dm_d = drv_d ? dminus_drive_code : 3'h0;
    end

    // Data line registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            src_prev_q <= 1'b0;
            drv_q <= 1'b0;
            dp_q <= 3'h0;
            dm_q <= 3'h0;
        end else begin
            src_prev_q <= src_s;
            drv_q <= drv_d;
            dp_q <= dp_d;
            dm_q <= dm_d;
        end
    end
    assign dplus_out = dp_q;
    assign dminus_out = dm_q;
    assign dplus_oe_n = !drv_q;
    assign dminus_oe_n = !drv_q;
    assign detect_busy = dif.busy;
    assign port_type = dif.port;

    cpc_port_det u_det (
        .core_clk(core_clk),
        .rst(rst),
        .dif(dif)
    );

    // charge needs allow bit and low enable
    AST_CHG_GATE: assert property (
        @(posedge core_clk) disable iff (rst)
        charge_active |-> $past(charger_allow_bit) && !$past(ce_n_s))
        else $error("Charging without allow and enable");
    // thermistor out of window suspends charging
    AST_TEMP: assert property (
        @(posedge core_clk) disable iff (rst)
        !temp_ok_s |=> !charge_active)
        else $error("Charging while temperature out of window");
    AST_BOOST: assert property (
        @(posedge core_clk) disable iff (rst)
        (boost_config_bit && boost_req_s) |=> boost_active)
        else $error("Boost not entered");
    AST_LIM_CODE: assert property (
        @(posedge core_clk) disable iff (rst)
        !pin_limit_select_bit
        |=> input_limit_eff == $past(input_limit_code))
        else $error("Limit not code when select low");
    AST_LIM_MIN: assert property (
        @(posedge core_clk) disable iff (rst)
        pin_limit_select_bit
        |=> input_limit_eff <= $past(input_limit_code))
        else $error("Limit above code limit");
    AST_LIM_FLOOR: assert property (
        @(posedge core_clk) disable iff (rst)
        (pin_limit_select_bit &&
            input_limit_code >= cpc_pkg::PIN_LIMIT_MIN_CODE)
        |=> input_limit_eff >= cpc_pkg::PIN_LIMIT_MIN_CODE)
        else $error("Limit below pin path floor");
    // charging without fault pulls indicator low in two cycles
    AST_STAT_LOW: assert property (
        @(posedge core_clk) disable iff (rst)
        (charging && !fault_s && !indicator_disable_bit)[*2]
        |-> !stat_oe_n)
        else $error("Indicator not low while charging");
    AST_INDICATOR_DISABLE_BIT: assert property (
        @(posedge core_clk) disable iff (rst)
        indicator_disable_bit |=> stat_oe_n)
        else $error("Indicator driven while disabled");
    // pulse starts on a status change
    AST_ALERT_START: assert property (
        @(posedge core_clk) disable iff (rst)
        (event_now && !al_q) |=> !alert_oe_n)
        else $error("Alert pulse not started");
    // alert released after a full pulse
    AST_ALERT_END: assert property (
        @(posedge core_clk) disable iff (rst)
        (al_q && al_cnt_q == 17'(cpc_pkg::ALERT_PULSE_CYC - 1))
        |=> alert_oe_n)
        else $error("Alert not released");
    // no drive without source or boost
    AST_DRV: assert property (
        @(posedge core_clk) disable iff (rst)
        (!src_s && !boost_q) |=> dplus_oe_n && dminus_oe_n)
        else $error("Data line driven without source");
endmodule // cpc_top
`default_nettype wire

// ===== verilog/cpc_pkg.sv
// Constants and types for the charger pin control logic
package cpc_pkg;
    // Clock rate and derived timing
    localparam int unsigned CLK_HZ = 250000000;
    localparam int unsigned CLK_PERIOD_NS = 4;
    // Alert pulse width in microseconds and in cycles
    localparam int unsigned ALERT_PULSE_US = 256;
    localparam int unsigned ALERT_PULSE_CYC =
        ALERT_PULSE_US * 1000 / CLK_PERIOD_NS;
    // Fault blink rate in hertz; half period in cycles
    localparam int unsigned BLINK_HZ = 1;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
    // Input current limit code: 50 mA steps from 100 mA
    localparam int unsigned INPUT_LIMIT_PIN_W = 6;
    localparam int unsigned INPUT_LIMIT_PIN_BASE_MA = 100;
    localparam int unsigned INPUT_LIMIT_PIN_STEP_MA = 50;
    // Lowest limit that the resistor path supports
    localparam int unsigned PIN_LIMIT_MIN_MA = 500;
    localparam logic [5:0] PIN_LIMIT_MIN_CODE =
        6'((PIN_LIMIT_MIN_MA - INPUT_LIMIT_PIN_BASE_MA) / INPUT_LIMIT_PIN_STEP_MA);
    // Data line drive code width
    localparam int unsigned DRV_W = 3;
    // Detection step length in cycles
    localparam int unsigned DET_STEP_CYC = 16;
    localparam logic [15:0] DET_STEP_LAST = 16'(DET_STEP_CYC - 1);
    // Reset values
    localparam logic STAT_RST = 1'b1;
    // Port type result codes
    typedef enum logic [2:0] {
        CPC_PORT_NONE, CPC_PORT_SDP, CPC_PORT_CDP, CPC_PORT_DCP, CPC_PORT_HV
    } cpc_port_t;
endpackage : cpc_pkg

// ===== verilog/cpc_det_if.sv
// Carrier between the control core and the port detector
`timescale 1ns/1ns
`default_nettype none
interface cpc_det_if;
    logic start;
    logic dp_in;
    logic dm_in;
    logic busy;
    logic done;
    cpc_pkg::cpc_port_t port;
    modport core (output start, output dp_in, output dm_in,
                  input busy, input done, input port);
    modport det (input start, input dp_in, input dm_in,
                 output busy, output done, output port);
endinterface : cpc_det_if
`default_nettype wire

// ===== verilog/cpc_port_det.sv
// Input port type detector on the USB data lines
`timescale 1ns/1ns
`default_nettype none
module cpc_port_det (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Core side
    cpc_det_if.det dif
);
    typedef enum logic [2:0] {
        DET_IDLE, DET_DCD, DET_PRI, DET_SEC, DET_HV, DET_DONE
    } cpc_det_state_t;

    cpc_det_state_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d;
    cpc_pkg::cpc_port_t port_q, port_d;
    logic step_end;

    assign step_end = (cnt_q == cpc_pkg::DET_STEP_LAST);

    // Next state: contact, primary, secondary then high voltage check
    always_comb begin
        st_d = st_q;
        port_d = port_q;
        cnt_d = step_end ? 16'h0000 : cnt_q + 16'h0001;
        unique case (st_q)
            DET_IDLE: begin
                cnt_d = 16'h0000;
                if (dif.start) begin
                    st_d = DET_DCD;
                    port_d = cpc_pkg::CPC_PORT_NONE;
                end
            end
            DET_DCD: if (step_end) st_d = DET_PRI;
            DET_PRI: if (step_end) begin
                if (dif.dm_in) begin
                    st_d = DET_SEC;
                end else begin
                    port_d = cpc_pkg::CPC_PORT_SDP;
                    st_d = DET_DONE;
                end
            end
            DET_SEC: if (step_end) begin
                if (dif.dp_in) begin
                    port_d = cpc_pkg::CPC_PORT_DCP;
                    st_d = DET_HV;
                end else begin
                    port_d = cpc_pkg::CPC_PORT_CDP;
                    st_d = DET_DONE;
                end
            end
            DET_HV: if (step_end) begin
                if (!dif.dp_in && dif.dm_in) port_d = cpc_pkg::CPC_PORT_HV;
                st_d = DET_DONE;
            end
            DET_DONE: st_d = DET_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= DET_IDLE;
            cnt_q <= 16'h0000;
            port_q <= cpc_pkg::CPC_PORT_NONE;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            port_q <= port_d;
        end
    end

    assign dif.busy = (st_q != DET_IDLE) && (st_q != DET_DONE);
    assign dif.done = (st_q == DET_DONE);
    assign dif.port = port_q;

    AST_DET_DONE: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(st_q == DET_DCD) |-> ##[32:64] (st_q == DET_DONE))
        else $error("Detection did not complete in time");
endmodule // cpc_port_det
`default_nettype wire

// ===== testbench/cpc_host_model.sv
// Host model: request pins and the attached USB port's data lines
`timescale 1ns/1ns
`default_nettype none
module cpc_host_model (
    // Clock
    input wire logic core_clk,
    // Requests from the bench
    input wire logic want_boost,
    input wire logic want_charge,
    input wire cpc_pkg::cpc_port_t port_kind,
    // Device side
    input wire logic detect_busy,
    input wire logic [2:0] dplus_out,
    input wire logic dplus_oe_n,
    input wire logic [2:0] dminus_out,
    input wire logic dminus_oe_n,
    output logic boost_request_pin,
    output logic charge_enable_n_pin,
    output logic dplus_in,
    output logic dminus_in
);
    int unsigned busy_cnt;
    logic port_dp;
    logic port_dm;
    initial begin
        boost_request_pin = 1'b0;
        charge_enable_n_pin = 1'b1;
        busy_cnt = 0;
    end
    // pins follow requests just after the edge
    always @(posedge core_clk) begin
        boost_request_pin <= #1 want_boost;
        charge_enable_n_pin <= #1 !want_charge;
        busy_cnt <= detect_busy ? busy_cnt + 1 : 0;
    end
    // port answers; high-voltage adapter drops D+ late
    always_comb begin
        port_dm = port_kind != cpc_pkg::CPC_PORT_SDP;
        port_dp = port_kind == cpc_pkg::CPC_PORT_DCP ||
            (port_kind == cpc_pkg::CPC_PORT_HV && busy_cnt < 47);
    end
    // device drive wins over the port's own level
    assign dplus_in = !dplus_oe_n ? |dplus_out : port_dp;
    assign dminus_in = !dminus_oe_n ? |dminus_out : port_dm;
endmodule // cpc_host_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the charger pin control logic
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct packed {
        logic [7:0] ctl;
        logic [5:0] code;
        logic [5:0] pin;
        logic [2:0] res;
        logic [5:0] eff;
    } cpc_row_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic want_boost = 1'b0, want_charge = 1'b0;
    cpc_pkg::cpc_port_t port_kind = cpc_pkg::CPC_PORT_SDP;
    logic bpin, cepin, dp_in, dm_in, stat_out, stat_oe_n, alert_out;
    logic alert_oe_n, dplus_oe_n, dminus_oe_n, boost_active;
    logic charge_active, detect_busy;
    logic dis = 1'b0, bcfg = 1'b0, allow = 1'b0, sel = 1'b0;
    logic therm = 1'b1, source = 1'b0, done = 1'b0, fault = 1'b0;
    logic [5:0] code = 6'h00, lpin = 6'h00, eff;
    logic [2:0] dp_out, dm_out;
    logic [2:0] dpc = 3'h5, dmc = 3'h2;
    cpc_pkg::cpc_port_t port_type;
    int n_errors = 0, comparisons = 0, n, k;
    cpc_row_t rows [14] = '{
        '{8'hE0, 6'h0A, 6'h04, 3'h4, 6'h0A},
        '{8'h60, 6'h0A, 6'h04, 3'h1, 6'h0A},
        '{8'hA0, 6'h0A, 6'h04, 3'h1, 6'h0A},
        '{8'hC0, 6'h0A, 6'h04, 3'h1, 6'h0A},
        '{8'hE1, 6'h0A, 6'h04, 3'h5, 6'h0A},
        '{8'hE2, 6'h0A, 6'h04, 3'h5, 6'h0A},
        '{8'hF8, 6'h0A, 6'h04, 3'h3, 6'h0A},
        '{8'hF0, 6'h0A, 6'h04, 3'h4, 6'h0A},
        '{8'hE8, 6'h0A, 6'h04, 3'h4, 6'h0A},
        '{8'hE4, 6'h0A, 6'h04, 3'h4, 6'h08},
        '{8'hE4, 6'h14, 6'h0C, 3'h4, 6'h0C},
        '{8'hE4, 6'h05, 6'h0C, 3'h4, 6'h05},
        '{8'hE0, 6'h05, 6'h02, 3'h4, 6'h05},
        '{8'hE4, 6'h3F, 6'h3F, 3'h4, 6'h3F}};
    // Clock at 250 MHz
    always #2 core_clk = ~core_clk;
    cpc_top i_cpc_top (.core_clk(core_clk), .rst(rst),
        .boost_request_pin(bpin), .charge_enable_n_pin(cepin),
        .stat_out(stat_out), .stat_oe_n(stat_oe_n), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n), .indicator_disable_bit(dis),
        .boost_config_bit(bcfg), .charger_allow_bit(allow),
        .pin_limit_select_bit(sel), .input_limit_code(code),
        .dplus_drive_code(dpc), .dminus_drive_code(dmc),
        .input_limit_pin(lpin), .thermistor_in(therm),
        .source_attached(source), .charge_done(done),
        .fault_present(fault), .dplus_in(dp_in), .dminus_in(dm_in),
        .dplus_out(dp_out), .dplus_oe_n(dplus_oe_n), .dminus_out(dm_out),
        .dminus_oe_n(dminus_oe_n), .boost_active(boost_active),
        .charge_active(charge_active), .input_limit_eff(eff),
        .detect_busy(detect_busy), .port_type(port_type));
    cpc_host_model i_cpc_host_model (.core_clk(core_clk),
        .want_boost(want_boost), .want_charge(want_charge),
        .port_kind(port_kind), .detect_busy(detect_busy),
        .dplus_out(dp_out), .dplus_oe_n(dplus_oe_n), .dminus_out(dm_out),
        .dminus_oe_n(dminus_oe_n), .boost_request_pin(bpin),
        .charge_enable_n_pin(cepin), .dplus_in(dp_in), .dminus_in(dm_in));
    // Compare one value and count it
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // Step n clock cycles, landing just after the edge
    task step(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    // Print counts and the verdict, then stop
    task summarize();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Fail and stop if a bounded wait on a design output ran to 300 cycles
    task expire(input int c);
        if (c >= 300) begin
            n_errors++;
            summarize();
        end
    endtask
    initial begin
        step(16);
        chk({stat_oe_n, alert_oe_n, dplus_oe_n, dminus_oe_n},
            16'h000F);
        chk(16'(port_type), 16'(cpc_pkg::CPC_PORT_NONE));
        rst = 1'b0;
        step(10);
        source = 1'b1;
        for (k = 0; k < 300 && alert_oe_n !== 1'b0; k++) step(1);
        expire(k);
        for (n = 0; n < 70000 && alert_oe_n === 1'b0; n++) begin
            if (n == 200)
                chk(16'(port_type), 16'(cpc_pkg::CPC_PORT_SDP));
            step(1);
        end
        chk(16'(n), 16'(cpc_pkg::ALERT_PULSE_CYC));
        for (n = 0, k = 0; k < 20; k++) begin
            if (alert_oe_n !== 1'b1 || alert_out !== 1'b0) n++;
            step(1);
        end
        chk(16'(n), 16'h0000);
        // Other port kinds; lines stay released while detecting
        for (int j = 2; j <= 4; j++) begin
            source = 1'b0;
            step(8);
            port_kind = cpc_pkg::cpc_port_t'(j);
            source = 1'b1;
            for (k = 0; k < 300 && detect_busy !== 1'b1; k++) step(1);
            expire(k);
            for (n = 0, k = 0; k < 300 && detect_busy === 1'b1; k++) begin
                if (dplus_oe_n !== 1'b1 || dminus_oe_n !== 1'b1) n++;
                step(1);
            end
            expire(k);
            step(3);
            chk(16'(n), 16'h0000);
            chk(16'(port_type), 16'(j));
        end
        // Data lines driven only with source or boost
        source = 1'b0;
        bcfg = 1'b1;
        want_boost = 1'b1;
        step(8);
        chk({dplus_oe_n, dminus_oe_n, 2'h0, dp_out, 1'h0, dm_out},
            16'h0052);
        // Each line follows its own drive code
        dpc = 3'h6;
        dmc = 3'h1;
        step(2);
        chk({dplus_oe_n, dminus_oe_n, 2'h0, dp_out, 1'h0, dm_out},
            16'h0061);
        want_boost = 1'b0;
        step(8);
        chk({dplus_oe_n, dminus_oe_n, 2'h0, dp_out, 1'h0, dm_out},
            16'h0600);
        source = 1'b1;
        step(120);
        // Table of enable, indicator and limit cases
        foreach (rows[r]) begin
            {allow, want_charge, therm, bcfg} = rows[r].ctl[7:4];
            {want_boost, sel, dis, done} = rows[r].ctl[3:0];
            code = rows[r].code;
            lpin = rows[r].pin;
            step(7);
            chk({charge_active, boost_active, stat_oe_n},
                rows[r].res);
            chk(16'(eff), 16'(rows[r].eff));
        end
        // Fault overrides the released indication after charge completes
        {allow, want_charge, therm, bcfg, want_boost, sel, dis, done} = 8'hE0;
        step(7);
        chk({stat_out, stat_oe_n, charge_active}, 16'h0001);
        done = 1'b1;
        step(7);
        chk({stat_out, stat_oe_n, charge_active}, 16'h0003);
        // First blink phase drives the pin low
        fault = 1'b1;
        step(7);
        chk({stat_out, stat_oe_n}, 16'h0000);
        dis = 1'b1;
        step(3);
        chk({stat_out, stat_oe_n}, 16'h0001);
        // Reset in mid-run returns outputs to their idle levels
        {fault, dis, done} = 3'h0;
        rst = 1'b1;
        step(3);
        chk({stat_oe_n, alert_oe_n, dplus_oe_n, dminus_oe_n},
            16'h000F);
        chk({charge_active, boost_active}, 16'h0000);
        chk(16'(port_type), 16'(cpc_pkg::CPC_PORT_NONE));
        // Pins reach the outputs on the third edge after release
        rst = 1'b0;
        step(1);
        chk({charge_active, alert_oe_n}, 16'h0001);
        step(1);
        chk({charge_active, alert_oe_n}, 16'h0001);
        step(1);
        chk({charge_active, alert_oe_n}, 16'h0002);
        summarize();
    end
endmodule // testbench
`default_nettype wire
